// ===== core/tws_pkg.sv
package tws_pkg;

    localparam int TWS_ADDR_W = 3;
    localparam int TWS_DATA_W = 8;
    localparam int TWS_XFER_BITS = 8;

    // Register byte offsets.
    localparam logic [2:0] TWS_MODE_OFS = 3'h0;
    localparam logic [2:0] TWS_CSEL_OFS = 3'h1;
    localparam logic [2:0] TWS_TXB_OFS = 3'h2;
    localparam logic [2:0] TWS_SR_OFS = 3'h3;
    localparam logic [2:0] TWS_STAT_OFS = 3'h4;
    localparam logic [2:0] TWS_MASK_OFS = 3'h5;
    localparam logic [2:0] TWS_PORT_OFS = 3'h6;

    // Mode register fields.
    localparam int TWS_MODE_EN_BIT = 7;
    localparam int TWS_MODE_TRMD_BIT = 6;
    localparam int TWS_MODE_DIR_BIT = 4;
    localparam int TWS_MODE_BUSY_BIT = 0;

    // Clock selection register fields.
    localparam int TWS_CSEL_CKP_BIT = 4;
    localparam int TWS_CSEL_DAP_BIT = 3;
    localparam int TWS_CSEL_CKS_LSB = 0;
    localparam logic [2:0] TWS_CKS_SLAVE = 3'h7;

    // Interrupt status and mask fields.
    localparam int TWS_IRQ_DONE_BIT = 0;

    // Port control fields.
    localparam int TWS_PORT_DIR_BIT = 1;
    localparam int TWS_PORT_LAT_BIT = 0;

    // Reset values.
    localparam logic [7:0] TWS_REG_RST = 8'h00;
    localparam logic TWS_PORT_DIR_RST = 1'b1;
    localparam logic TWS_PORT_LAT_RST = 1'b0;
    localparam logic TWS_SCK_IDLE_RST = 1'b1;

    typedef enum logic [1:0]
    {
        TWS_IDLE = 2'b01,
        TWS_RUN = 2'b10
    } tws_st_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } tws_bus_req_t;

    typedef struct packed
    {
        logic en;
        logic trmd;
        logic dir;
        logic ckp;
        logic dap;
        logic [2:0] cks;
        logic [7:0] txb;
        logic [7:0] sr;
        logic out_latch;
        logic loaded;
        logic [3:0] cnt;
        tws_st_t st;
        logic stat;
        logic mask;
        logic pdir;
        logic plat;
        logic sck_s1;
        logic sck_s2;
        logic si_s1;
        logic si_s2;
        logic prev;
        logic int_sck;
        logic [2:0] div;
        logic [7:0] rdata;
        logic so_pin;
        logic so_oe;
        logic sck_out;
        logic sck_oe;
        logic irq;
    } tws_state_t;

endpackage

// ===== core/tws_shifter.sv
module tws_shifter #(
    parameter int XFER_BITS = tws_pkg::TWS_XFER_BITS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire tws_pkg::tws_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic serial_clk_pin_in,
    output logic serial_clk_pin_out,
    output logic serial_clk_pin_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe,
    output logic xfer_done_irq
);

    initial
    begin
        if (XFER_BITS < 1 || XFER_BITS > 8)
        begin
            $error("XFER_BITS must lie between 1 and 8.");
        end
    end

    localparam logic [3:0] LAST_CNT = 4'(XFER_BITS);

    tws_pkg::tws_state_t q;
    tws_pkg::tws_state_t n;

    logic master;
    logic lvl;
    logic rise;
    logic fall;
    logic drive_e;
    logic samp_e;
    logic out_e;
    logic in_e;
    logic start;
    logic idle;
    logic so_val;
    logic [7:0] base;

    always_comb
    begin
        n = q;
        start = 1'b0;
        base = 8'h00;
        so_val = 1'b0;
        n.rdata = 8'h00;
        idle = (q.st == tws_pkg::TWS_IDLE);
        // Slave operation takes the clock from the pin.
        master = (q.cks != tws_pkg::TWS_CKS_SLAVE);
        // The first synchroniser stage feeds only the second.
        n.sck_s1 = serial_clk_pin_in;
        n.sck_s2 = q.sck_s1;
        n.si_s1 = serial_in_pin;
        n.si_s2 = q.si_s1;
        lvl = master ? q.int_sck : q.sck_s2;
        n.prev = lvl;
        rise = ~q.prev & lvl;
        fall = q.prev & ~lvl;
        drive_e = q.ckp ? rise : fall;
        samp_e = q.ckp ? fall : rise;
        out_e = q.dap ? samp_e : drive_e;
        in_e = q.dap ? drive_e : samp_e;

        if (bus_req.wr)
        begin
            if (bus_req.addr == tws_pkg::TWS_MODE_OFS)
            begin
                n.en = bus_req.wdata[tws_pkg::TWS_MODE_EN_BIT];
                n.trmd = bus_req.wdata[tws_pkg::TWS_MODE_TRMD_BIT];
                n.dir = bus_req.wdata[tws_pkg::TWS_MODE_DIR_BIT];
            end
            else if (bus_req.addr == tws_pkg::TWS_CSEL_OFS)
            begin
                n.ckp = bus_req.wdata[tws_pkg::TWS_CSEL_CKP_BIT];
                n.dap = bus_req.wdata[tws_pkg::TWS_CSEL_DAP_BIT];
                n.cks = bus_req.wdata[tws_pkg::TWS_CSEL_CKS_LSB +: 3];
            end
            else if (bus_req.addr == tws_pkg::TWS_TXB_OFS)
            begin
                n.txb = bus_req.wdata;
                start = q.en & q.trmd & idle;
            end
            else if (bus_req.addr == tws_pkg::TWS_STAT_OFS)
            begin
                if (bus_req.wdata[tws_pkg::TWS_IRQ_DONE_BIT])
                begin
                    n.stat = 1'b0;
                end
            end
            else if (bus_req.addr == tws_pkg::TWS_MASK_OFS)
            begin
                n.mask = bus_req.wdata[tws_pkg::TWS_IRQ_DONE_BIT];
            end
            else if (bus_req.addr == tws_pkg::TWS_PORT_OFS)
            begin
                n.pdir = bus_req.wdata[tws_pkg::TWS_PORT_DIR_BIT];
                n.plat = bus_req.wdata[tws_pkg::TWS_PORT_LAT_BIT];
            end
        end

        if (bus_req.rd)
        begin
            if (bus_req.addr == tws_pkg::TWS_MODE_OFS)
            begin
                n.rdata = {q.en, q.trmd, 1'b0, q.dir, 3'h0, ~idle};
            end
            else if (bus_req.addr == tws_pkg::TWS_CSEL_OFS)
            begin
                n.rdata = {3'h0, q.ckp, q.dap, q.cks};
            end
            else if (bus_req.addr == tws_pkg::TWS_TXB_OFS)
            begin
                n.rdata = q.txb;
            end
            else if (bus_req.addr == tws_pkg::TWS_SR_OFS)
            begin
                n.rdata = q.sr;
                start = q.en & ~q.trmd & idle;
            end
            else if (bus_req.addr == tws_pkg::TWS_STAT_OFS)
            begin
                n.rdata = {7'h00, q.stat};
            end
            else if (bus_req.addr == tws_pkg::TWS_MASK_OFS)
            begin
                n.rdata = {7'h00, q.mask};
            end
            else if (bus_req.addr == tws_pkg::TWS_PORT_OFS)
            begin
                n.rdata = {6'h00, q.pdir, q.plat};
            end
        end

        case (q.st)
            tws_pkg::TWS_IDLE:
            begin
                n.int_sck = ~q.ckp;
                n.div = 3'h0;
                if (start)
                begin
                    n.st = tws_pkg::TWS_RUN;
                    n.cnt = 4'h0;
                    n.loaded = 1'b0;
                    if (q.dap)
                    begin
                        // First bit leaves the buffer with the strobe.
                        n.out_latch = q.dir ? n.txb[0] : n.txb[7];
                    end
                end
            end
            tws_pkg::TWS_RUN:
            begin
                if (q.div == q.cks)
                begin
                    n.div = 3'h0;
                    n.int_sck = ~q.int_sck;
                end
                else
                begin
                    n.div = q.div + 3'h1;
                end
                if (out_e)
                begin
                    if (!q.loaded)
                    begin
                        n.out_latch = q.dir ? q.txb[0] : q.txb[7];
                    end
                    else
                    begin
                        n.out_latch = q.dir ? q.sr[0] : q.sr[7];
                    end
                end
                if (in_e)
                begin
                    // Buffer loads into the shift register on the first input edge.
                    base = q.loaded ? q.sr : q.txb;
                    if (q.dir)
                    begin
                        n.sr = {q.si_s2, base[7:1]};
                    end
                    else
                    begin
                        n.sr = {base[6:0], q.si_s2};
                    end
                    n.loaded = 1'b1;
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt + 4'h1 == LAST_CNT)
                    begin
                        // Output latch is left alone, so the last bit stays.
                        n.st = tws_pkg::TWS_IDLE;
                        n.stat = 1'b1;
                        n.int_sck = ~q.ckp;
                    end
                end
            end
            default:
            begin
                n.st = tws_pkg::TWS_IDLE;
            end
        endcase

        if (!n.en)
        begin
            n.st = tws_pkg::TWS_IDLE;
            n.sr = 8'h00;
            n.out_latch = 1'b0;
            n.loaded = 1'b0;
            n.cnt = 4'h0;
            n.div = 3'h0;
            n.int_sck = ~n.ckp;
        end

        if (n.en)
        begin
            so_val = n.trmd & n.out_latch;
        end
        else if (!n.trmd)
        begin
            so_val = 1'b0;
        end
        else if (!n.dap)
        begin
            so_val = n.out_latch;
        end
        else
        begin
            so_val = n.dir ? n.txb[0] : n.txb[7];
        end
        // Output follows the new mode bits in the same update.
        n.so_pin = so_val | n.plat;
        n.so_oe = ~n.pdir;
        n.sck_out = n.int_sck;
        n.sck_oe = n.en & (n.cks != tws_pkg::TWS_CKS_SLAVE);
        n.irq = n.stat & n.mask;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= tws_pkg::TWS_IDLE;
            q.txb <= tws_pkg::TWS_REG_RST;
            q.sr <= tws_pkg::TWS_REG_RST;
            q.rdata <= tws_pkg::TWS_REG_RST;
            q.pdir <= tws_pkg::TWS_PORT_DIR_RST;
            q.plat <= tws_pkg::TWS_PORT_LAT_RST;
            q.int_sck <= tws_pkg::TWS_SCK_IDLE_RST;
            q.sck_out <= tws_pkg::TWS_SCK_IDLE_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign bus_rdata = q.rdata;
    assign serial_clk_pin_out = q.sck_out;
    assign serial_clk_pin_oe = q.sck_oe;
    assign serial_out_pin_out = q.so_pin;
    assign serial_out_pin_oe = q.so_oe;
    assign xfer_done_irq = q.irq;

endmodule

// ===== tb/tws_assertions.sv
module tws_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire tws_pkg::tws_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic serial_clk_pin_oe,
    input wire logic serial_out_pin_out,
    input wire logic serial_out_pin_oe,
    input wire logic xfer_done_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic en, trmd, dir, dap, msk, pdir, lat, w1, w2, qt;
    logic [2:0] cks;
    logic [7:0] txb, w;
    assign w = bus_req.wdata;
    assign qt = !w1 && !w2;
    // Shadow copy of the writable fields other than clock polarity and status.
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            {en, trmd, dir, dap, cks, txb, msk, pdir, lat} <= 18'h2;
        else if (bus_req.wr)
            case (bus_req.addr)
                3'h0: {en, trmd, dir} <= {w[7:6], w[4]};
                3'h1: {dap, cks} <= w[3:0];
                3'h2: txb <= w;
                3'h5: msk <= w[0];
                3'h6: {pdir, lat} <= w[1:0];
                default: ;
            endcase
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            {w1, w2} <= 2'h0;
        else
            {w1, w2} <= {bus_req.wr, w1};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    property p_rd_idle;
        !$past(bus_req.rd) |-> bus_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
    property p_rd_hole;
        bus_req.rd && bus_req.addr == 3'h7 |=> bus_rdata == 8'h00;
    endproperty
    a_rd_hole: assert property (p_rd_hole) else $error("hole read");
    property p_mode_rd;
        $past(bus_req.rd) && $past(bus_req.addr) == 3'h0 |->
            {bus_rdata[7:1], bus_rdata[0] & !en} ==
            {en, trmd, 1'b0, dir, 4'h0};
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read");
    property p_sck_oe;
        qt |-> serial_clk_pin_oe == (en && cks != 3'h7);
    endproperty
    a_sck_oe: assert property (p_sck_oe) else $error("clock oe");
    property p_so_dis;
        qt && !en |-> serial_out_pin_out ==
            (lat | (trmd & dap & (dir ? txb[0] : txb[7])));
    endproperty
    a_so_dis: assert property (p_so_dis) else $error("idle out");
    property p_so_oe;
        qt |-> serial_out_pin_oe == !pdir;
    endproperty
    a_so_oe: assert property (p_so_oe) else $error("out oe");
    property p_irq_clr;
        bus_req.wr && bus_req.addr == 3'h4 && w[0] |-> ##2 !xfer_done_irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq clear");
    property p_irq_msk;
        xfer_done_irq |-> msk;
    endproperty
    a_irq_msk: assert property (p_irq_msk) else $error("irq mask");
endmodule

// ===== tb/tws_peer.sv
module tws_peer (
    input wire logic sck,
    input wire logic so,
    input wire logic go,
    input wire logic gen,
    input wire logic dap,
    input wire logic [7:0] pb,
    output logic si,
    output logic sck_gen,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    initial
    begin
        sck_gen = 1'b1;
        si = 1'b0;
        rx = 8'h00;
        sh = 8'h00;
    end
    // Data leaves on one clock edge and is taken on the other.
    always @(sck)
        if (sck == dap)
        begin
            si = sh[7];
            sh = {sh[6:0], ~sh[7]};
        end
        else
            rx = {rx[6:0], so};
    always @(posedge go)
    begin
        si = dap ? pb[7] : ~pb[7];
        sh = dap ? {pb[6:0], 1'b0} : pb;
        if (gen)
        begin
            #195;
            repeat (16) #400 sck_gen = ~sck_gen;
        end
    end
endmodule

// ===== tb/test_three_wire_serial_shifter.sv
module test_three_wire_serial_shifter;
    timeunit 1ns;
    timeprecision 1ns;
    // Rows hold mode, clock select, transmit byte and peer byte.
    localparam logic [31:0] ROWS [5] = '{32'hc003_55aa, 32'hd003_3cc1,
        32'hc00b_a55a, 32'hd00f_817e, 32'hc007_0ff0};
    localparam logic [15:0] DIS [5] = '{16'h0840, 16'h0850, 16'h0800,
        16'h0050, 16'h0000};
    logic mclk, rst, go, gen, dap, si, so, so_oe, irq;
    logic sck_out, sck_oe, peer_sck, sck_line;
    logic [7:0] bus_rdata, pb, prx, d;
    logic [31:0] r;
    tws_pkg::tws_bus_req_t bus_req;
    int errors, check_count;
    assign sck_line = sck_oe ? sck_out : peer_sck;
    tws_shifter u_dut (.mclk(mclk), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .serial_clk_pin_in(sck_line),
        .serial_clk_pin_out(sck_out), .serial_clk_pin_oe(sck_oe),
        .serial_in_pin(si), .serial_out_pin_out(so),
        .serial_out_pin_oe(so_oe), .xfer_done_irq(irq));
    tws_peer u_peer (.sck(sck_line), .so(so_oe ? so : 1'b1), .go(go),
        .gen(gen), .dap(dap), .pb(pb), .si(si), .sck_gen(peer_sck),
        .rx(prx));
    function automatic logic [7:0] rev(input logic [7:0] v);
        rev = {<<{v}};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        bus_req <= '{1'b1, 1'b0, a, v};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
        v = bus_rdata;
    endtask
    task automatic kick();
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    task automatic wait_irq();
        repeat (400)
            if (irq !== 1'b1)
                @(posedge mclk);
        chk({7'h0, irq}, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        #1000000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        rst = 1'b1;
        bus_req = '0;
        {go, gen, dap, pb} = 11'h0;
        errors = 0;
        check_count = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), d);
            chk(d, a == 6 ? 8'h02 : 8'h00);
        end
        // Idle output levels are judged by the checker while disabled.
        wr(3'h2, 8'h01);
        foreach (DIS[k])
        begin
            wr(3'h1, DIS[k][15:8]);
            wr(3'h0, DIS[k][7:0]);
            wr(3'h6, {7'h0, k[0]});
            repeat (3) @(posedge mclk);
        end
        wr(3'h5, 8'h01);
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            wr(3'h0, 8'h00);
            wr(3'h1, r[23:16]);
            wr(3'h0, r[31:24]);
            pb <= r[7:0];
            dap <= r[19];
            gen <= r[18:16] == 3'h7;
            kick();
            wr(3'h2, r[15:8]);
            wait_irq();
            chk({7'h0, so}, {7'h0, r[28] ? r[15] : r[8]});
            rd(3'h3, d);
            chk(d, r[28] ? rev(r[7:0]) : r[7:0]);
            chk(prx, r[28] ? rev(r[15:8]) : r[15:8]);
            rd(3'h0, d);
            chk(d, r[31:24]);
            wr(3'h4, 8'h01);
            repeat (2) @(posedge mclk);
            chk({7'h0, irq}, 8'h00);
        end
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h03);
        wr(3'h0, 8'h80);
        pb <= 8'h96;
        {dap, gen} <= 2'h0;
        kick();
        rd(3'h3, d);
        wait_irq();
        wr(3'h4, 8'h01);
        rd(3'h3, d);
        chk(d, 8'h96);
        wait_irq();
        wr(3'h5, 8'h00);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h00);
        wr(3'h5, 8'h01);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h01);
        wr(3'h0, 8'h00);
        rd(3'h3, d);
        chk(d, 8'h00);
        report_and_stop();
    end
endmodule
bind tws_shifter tws_chk u_chk (.mclk(mclk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .serial_clk_pin_oe(serial_clk_pin_oe),
    .serial_out_pin_out(serial_out_pin_out),
    .serial_out_pin_oe(serial_out_pin_oe), .xfer_done_irq(xfer_done_irq));
